// File: pkg/cmit_defs.vh
/*
 Constants for the four-channel compare match interval timer: register offsets,
 field positions, reset values and mode codes. Assumes inclusion by bare name.
*/
`ifndef CMIT_DEFS_VH
`define CMIT_DEFS_VH

// ----------------------------------------
// register map, per channel stride 0x20
// ----------------------------------------
`define CMIT_CH_STRIDE 8'h20
`define CMIT_OFS_CTRL 5'h00
`define CMIT_OFS_CMP 5'h04
`define CMIT_OFS_FLAG 5'h08
`define CMIT_OFS_CNT 5'h0C
`define CMIT_OFS_SRC 5'h10
`define CMIT_OFS_IRQ_STAT 8'h80
`define CMIT_OFS_IRQ_MASK 8'h84

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CMIT_CTRL_EN 30
`define CMIT_CTRL_IRQ_EN 29
`define CMIT_CTRL_MODE_HI 28
`define CMIT_CTRL_MODE_LO 27
`define CMIT_CTRL_CLR 26
`define CMIT_CTRL_ACT 25
`define CMIT_CTRL_PRE_HI 7
`define CMIT_CTRL_PRE_LO 0
`define CMIT_CTRL_RST 32'h0000_0005
`define CMIT_PRE_RST 8'h05

// ----------------------------------------
// modes
// ----------------------------------------
`define CMIT_MODE_ONESHOT 2'h0
`define CMIT_MODE_PERIODIC 2'h1
`define CMIT_MODE_TOGGLE 2'h2
`define CMIT_MODE_CONT 2'h3

`endif

// File: hdl/cmit_sync.v
/*
 Two-flop synchroniser for one level.
 Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module cmit_sync (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// level
	input wire d,
	output wire q
);
	reg s1_r;
	reg s2_r;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
		end
	end
	assign q = s2_r;
endmodule
`default_nettype wire

// File: hdl/cmit_chan.v
/*
 One timer channel: source pick, prescaler, 24-bit up-counter, compare match,
 toggle output. Assumes control fields come from the register block on hclk
 and the source ticks are already synchronised single-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cmit_defs.vh"
module cmit_chan #(
	parameter CW = 24,
	parameter PW = 8
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// control
	input wire [3:0] src_tick,
	input wire [1:0] src_sel,
	input wire [PW-1:0] prescale,
	input wire [1:0] mode,
	input wire [CW-1:0] compare_field,
	input wire count_enable,
	input wire counter_clear,
	// status
	output reg [CW-1:0] count_r,
	output wire match,
	output reg tout_r
);
	reg [PW-1:0] pre_r;
	wire tick = src_tick[src_sel];
	wire pre_done = (pre_r == prescale);
	wire step = count_enable && tick && pre_done;
	wire [CW-1:0] cnt_inc = count_r + {{(CW-1){1'b0}}, 1'b1};
	// match when the incremented count reaches compare: interval = (pre+1)*cmp
	assign match = step && (cnt_inc == compare_field);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_r <= {PW{1'b0}};
			count_r <= {CW{1'b0}};
			tout_r <= 1'b0;
		end else if (counter_clear) begin
			pre_r <= {PW{1'b0}};
			count_r <= {CW{1'b0}};
		end else if (count_enable && tick) begin
			pre_r <= pre_done ? {PW{1'b0}} : pre_r + {{(PW-1){1'b0}}, 1'b1};
			if (pre_done) begin
				if (match && mode != `CMIT_MODE_CONT)
					count_r <= {CW{1'b0}};
				else
					count_r <= cnt_inc;
				if (match && mode == `CMIT_MODE_TOGGLE)
					tout_r <= ~tout_r;
			end
		end
	end
endmodule
`default_nettype wire

// File: hdl/cmit_top.v
/*
 Four-channel compare match interval timer with an AHB-Lite slave.
 Assumes a single AHB-Lite master, word transfers, and clock sources on pins
 that are asynchronous to hclk (hclk itself is source 0).
*/
`timescale 1ns/1ns
`default_nettype none
`include "cmit_defs.vh"
module cmit_top #(
	parameter NCH = 4,
	parameter CW = 24,
	parameter PW = 8
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// clock source pins
	input wire [2:0] ext_clk_src,
	// outputs
	output reg [NCH-1:0] toggle_out,
	output reg [NCH-1:0] chan_irq,
	output reg irq
);
	// ----------------------------------------
	// source clocks: sync then edge detect
	// ----------------------------------------
	wire [2:0] src_s;
	reg [2:0] src_d_r;
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gsync
			cmit_sync u_sync (
				.clk(hclk),
				.rst_n(hresetn),
				.d(ext_clk_src[g]),
				.q(src_s[g])
			);
		end
	endgenerate
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			src_d_r <= 3'h0;
		else
			src_d_r <= src_s;
	end
	wire [3:0] ticks = {src_s & ~src_d_r, 1'b1};

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [NCH-1:0] en_r;
	reg [NCH-1:0] irq_en_r;
	reg [2*NCH-1:0] mode_r;
	reg [PW*NCH-1:0] pre_r;
	reg [CW*NCH-1:0] cmp_r;
	reg [2*NCH-1:0] src_r;
	reg [NCH-1:0] flag_r;
	reg [NCH-1:0] stat_r;
	reg [NCH-1:0] mask_r;
	reg [NCH-1:0] clr_r;
	wire [CW*NCH-1:0] cnt_w;
	wire [NCH-1:0] match_w;
	wire [NCH-1:0] tout_w;

	generate
		for (g = 0; g < NCH; g = g + 1) begin : gch
			cmit_chan #(.CW(CW), .PW(PW)) u_ch (
				.hclk(hclk),
				.hresetn(hresetn),
				.src_tick(ticks),
				.src_sel(src_r[2*g+1:2*g]),
				.prescale(pre_r[PW*g+PW-1:PW*g]),
				.mode(mode_r[2*g+1:2*g]),
				.compare_field(cmp_r[CW*g+CW-1:CW*g]),
				.count_enable(en_r[g]),
				.counter_clear(clr_r[g]),
				.count_r(cnt_w[CW*g+CW-1:CW*g]),
				.match(match_w[g]),
				.tout_r(tout_w[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// ahb-lite address phase capture
	// ----------------------------------------
	reg dp_wr_r;
	reg [7:0] dp_addr_r;
	wire take = hsel && hready && htrans[1];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r <= 1'b0;
			dp_addr_r <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			dp_wr_r <= take && hwrite;
			if (take)
				dp_addr_r <= haddr;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// read data is registered in the data phase cycle following address
	wire [1:0] a_ch = haddr[6:5];
	wire [4:0] a_ofs = haddr[4:0];
	wire [1:0] w_ch = dp_addr_r[6:5];
	wire [4:0] w_ofs = dp_addr_r[4:0];
	wire w_chan = dp_wr_r && !dp_addr_r[7];

	reg [31:0] rd_nxt;
	integer i;
	always @* begin
		rd_nxt = 32'h0000_0000;
		if (haddr[7]) begin
			if (haddr == `CMIT_OFS_IRQ_STAT)
				rd_nxt[NCH-1:0] = stat_r;
			else if (haddr == `CMIT_OFS_IRQ_MASK)
				rd_nxt[NCH-1:0] = mask_r;
		end else if (a_ofs == `CMIT_OFS_CTRL) begin
			rd_nxt[`CMIT_CTRL_EN] = en_r[a_ch];
			rd_nxt[`CMIT_CTRL_IRQ_EN] = irq_en_r[a_ch];
			rd_nxt[`CMIT_CTRL_MODE_HI:`CMIT_CTRL_MODE_LO] = mode_r[2*a_ch +: 2];
			rd_nxt[`CMIT_CTRL_ACT] = en_r[a_ch];
			rd_nxt[`CMIT_CTRL_PRE_HI:`CMIT_CTRL_PRE_LO] = pre_r[PW*a_ch +: PW];
		end else if (a_ofs == `CMIT_OFS_CMP) begin
			rd_nxt[CW-1:0] = cmp_r[CW*a_ch +: CW];
		end else if (a_ofs == `CMIT_OFS_FLAG) begin
			rd_nxt[0] = flag_r[a_ch];
		end else if (a_ofs == `CMIT_OFS_CNT) begin
			rd_nxt[CW-1:0] = cnt_w[CW*a_ch +: CW];
		end else if (a_ofs == `CMIT_OFS_SRC) begin
			rd_nxt[1:0] = src_r[2*a_ch +: 2];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (take && !hwrite)
			hrdata <= rd_nxt;
	end

	// ----------------------------------------
	// register writes and hardware updates
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_r <= {NCH{1'b0}};
			irq_en_r <= {NCH{1'b0}};
			mode_r <= {2*NCH{1'b0}};
			pre_r <= {NCH{`CMIT_PRE_RST}};
			cmp_r <= {CW*NCH{1'b0}};
			src_r <= {2*NCH{1'b0}};
			flag_r <= {NCH{1'b0}};
			stat_r <= {NCH{1'b0}};
			mask_r <= {NCH{1'b0}};
			clr_r <= {NCH{1'b0}};
		end else begin
			clr_r <= {NCH{1'b0}};
			for (i = 0; i < NCH; i = i + 1) begin
				if (w_chan && w_ch == i) begin
					if (w_ofs == `CMIT_OFS_CTRL) begin
						irq_en_r[i] <= hwdata[`CMIT_CTRL_IRQ_EN];
						mode_r[2*i +: 2] <= hwdata[`CMIT_CTRL_MODE_HI:`CMIT_CTRL_MODE_LO];
						pre_r[PW*i +: PW] <= hwdata[`CMIT_CTRL_PRE_HI:`CMIT_CTRL_PRE_LO];
						// re-enable keeps the count; only the clear bit zeroes it
						en_r[i] <= hwdata[`CMIT_CTRL_EN] && !hwdata[`CMIT_CTRL_CLR];
						clr_r[i] <= hwdata[`CMIT_CTRL_CLR];
					end else if (w_ofs == `CMIT_OFS_CMP) begin
						cmp_r[CW*i +: CW] <= hwdata[CW-1:0];
					end else if (w_ofs == `CMIT_OFS_FLAG && hwdata[0]) begin
						flag_r[i] <= 1'b0;
					end else if (w_ofs == `CMIT_OFS_SRC) begin
						src_r[2*i +: 2] <= hwdata[1:0];
					end
				end
				// one-shot stops on every match, interrupt enabled or not
				if (match_w[i] && mode_r[2*i +: 2] == `CMIT_MODE_ONESHOT)
					en_r[i] <= 1'b0;
				if (match_w[i] && irq_en_r[i])
					flag_r[i] <= 1'b1;
			end
			if (dp_wr_r && dp_addr_r == `CMIT_OFS_IRQ_MASK)
				mask_r <= hwdata[NCH-1:0];
			// clear at the edge that captures hrdata, so no event slips in
			// unread between capture and clear; a same-cycle event wins
			if (take && !hwrite && haddr == `CMIT_OFS_IRQ_STAT)
				stat_r <= match_w & irq_en_r;
			else
				stat_r <= stat_r | (match_w & irq_en_r);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			toggle_out <= {NCH{1'b0}};
			chan_irq <= {NCH{1'b0}};
			irq <= 1'b0;
		end else begin
			toggle_out <= tout_w;
			chan_irq <= flag_r & irq_en_r;
			irq <= |(stat_r & mask_r);
		end
	end
endmodule
`default_nettype wire

// File: testbench/cmit_chk.sv
/*
 Port checker for the timer top.
 Assumes one clock, reset async active low.
*/
`timescale 1ns/1ns
`default_nettype none
module cmit_chk #(parameter NCH = 4) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// outputs
	input wire logic [NCH-1:0] toggle_out,
	input wire logic [NCH-1:0] chan_irq,
	input wire logic irq
);
	// ----------
	// access history
	// ----------
	logic [2:0] tk_r;
	logic [2:0] wk_r;
	wire logic tk = hsel & hready & htrans[1];
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tk_r <= 3'h0;
			wk_r <= 3'h0;
		end else begin
			tk_r <= {tk_r[1:0], tk};
			wk_r <= {wk_r[1:0], tk & hwrite};
		end
	end
	property p_okay; hresp == 1'h0 && hreadyout; endproperty
	a_okay: assert property (p_okay) else $error("bus answer not okay");
	property p_rst; $rose(hresetn) |-> hrdata == 32'h0 && irq == 1'h0 && chan_irq == '0; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_rdhold; !$past(tk && !hwrite) |-> $stable(hrdata); endproperty
	a_rdhold: assert property (p_rdhold) else $error("read data moved");
	property p_flag; |($past(chan_irq) & ~chan_irq) |-> |wk_r; endproperty
	a_flag: assert property (p_flag) else $error("request dropped alone");
	property p_irqhold; $fell(irq) |-> |tk_r; endproperty
	a_irqhold: assert property (p_irqhold) else $error("irq dropped alone");
	property p_irqsrc; $rose(irq) && !(|tk_r) |-> ##[0:2] |chan_irq; endproperty
	a_irqsrc: assert property (p_irqsrc) else $error("irq without match");
	property p_tog; toggle_out != $past(toggle_out) |=> toggle_out == $past(toggle_out); endproperty
	a_tog: assert property (p_tog) else $error("toggle too fast");
	property p_idle; !(|tk_r) && !tk |=> hreadyout; endproperty
	a_idle: assert property (p_idle) else $error("ready low");
	c_irq: cover property ($rose(irq));
	c_chan: cover property ($rose(|chan_irq));
	c_tog: cover property ($rose(|toggle_out));
endmodule
bind cmit_top cmit_chk #(.NCH(NCH)) cmit_chk_inst (.hclk, .hresetn, .hsel, .htrans,
	.hwrite, .hready, .hrdata, .hreadyout, .hresp, .toggle_out, .chan_irq, .irq);
`default_nettype wire

// File: testbench/cmit_ahb_bfm.sv
/*
 AHB-Lite master model: single word transfers.
 Assumes tasks are entered just after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module cmit_ahb_bfm (
	// bus
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output var logic hsel,
	output var logic [7:0] haddr,
	output var logic [1:0] htrans,
	output var logic hwrite,
	output var logic [2:0] hsize,
	output var logic [31:0] hwdata
);
	initial begin
		hsel = 1'h0;
		haddr = 8'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'h1);
		q = hrdata;
	endtask
endmodule
`default_nettype wire

// File: testbench/cmit_tb_top.sv
/*
 Self-checking bench for the four-channel timer.
 Assumes the bus model is the only master.
*/
`timescale 1ns/1ns
`default_nettype none
module cmit_tb_top;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize, ext_clk_src;
	logic [31:0] hwdata, hrdata, q, a;
	logic [3:0] toggle_out, chan_irq;
	int fails, num_checks, n;
	cmit_top cmit_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_clk_src,
		.toggle_out, .chan_irq, .irq);
	cmit_ahb_bfm cmit_ahb_bfm_inst (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata);
	initial begin
		hclk = 1'h0;
		forever #25 hclk = ~hclk;
	end
	// ----------
	// helpers
	// ----------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		cmit_ahb_bfm_inst.xfer(1'h1, ad, d, q);
	endtask
	task automatic rd(input logic [7:0] ad);
		cmit_ahb_bfm_inst.xfer(1'h0, ad, 32'h0, q);
	endtask
	// settle past the edge before looking
	task automatic cyc(input int k);
		repeat (k) @(posedge hclk);
		#1;
	endtask
	task automatic wt(input int k, input logic v, input logic tg);
		for (int i = 0; i < 300 && (tg ? toggle_out[k] : chan_irq[k]) !== v; i++)
			cyc(1);
		chk(tg ? toggle_out[k] : chan_irq[k], v);
	endtask
	task automatic print_verdict;
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----------
	// scenarios
	// ----------
	task automatic t_reset;
		rd(8'h00);
		chk(q, 32'h5);
		wr(8'h14, 32'hFFFF_FFFF);
		rd(8'h14);
		chk(q, 32'h0);
	endtask
	task automatic t_oneshot;
		wr(8'h84, 32'hF);
		wr(8'h04, 32'h6);
		wr(8'h00, 32'h6000_0001);
		wt(0, 1'h1, 1'h0);
		cyc(1);
		chk(irq, 1'h1);
		rd(8'h00);
		chk(q, 32'h2000_0001);
		rd(8'h0C);
		chk(q, 32'h0);
		rd(8'h80);
		chk(q, 32'h1);
		rd(8'h80);
		chk(q, 32'h0);
		chk(irq, 1'h0);
		chk(chan_irq[0], 1'h1);
		wr(8'h08, 32'h1);
		cyc(3);
		chk(chan_irq[0], 1'h0);
	endtask
	task automatic t_toggle;
		wr(8'h44, 32'h5);
		wr(8'h40, 32'h7000_0002);
		wt(2, 1'h1, 1'h1);
		for (int j = 0; j < 2; j++) begin
			n = 0;
			do begin
				cyc(1);
				n++;
			end while (toggle_out[2] === (j == 0) && n < 99);
			chk(n, 15);
		end
		rd(8'h40);
		chk(q, 32'h7200_0002);
		wr(8'h84, 32'h0);
		rd(8'h80);
		wr(8'h48, 32'h1);
		wt(2, 1'h0, 1'h0);
		wt(2, 1'h1, 1'h0);
		chk(chan_irq[2], 1'h1);
		chk(irq, 1'h0);
		rd(8'h80);
		chk(q, 32'h4);
		wr(8'h40, 32'h0);
	endtask
	task automatic t_cont;
		wr(8'h64, 32'h8);
		wr(8'h60, 32'h7800_0000);
		wt(3, 1'h1, 1'h0);
		rd(8'h6C);
		a = q;
		chk(a > 32'h8, 1'h1);
		rd(8'h6C);
		chk(q > a, 1'h1);
		a = q + 32'h28;
		wr(8'h64, a);
		wr(8'h68, 32'h1);
		wt(3, 1'h0, 1'h0);
		wt(3, 1'h1, 1'h0);
		rd(8'h6C);
		chk(q - a < 32'h8, 1'h1);
		wr(8'h60, 32'h0);
	endtask
	task automatic t_clear;
		wr(8'h24, 32'h3);
		wr(8'h20, 32'h4000_0000);
		cyc(20);
		chk(chan_irq[1], 1'h0);
		rd(8'h20);
		chk(q, 32'h0);
		wr(8'h24, 32'h00FF_FFFF);
		wr(8'h20, 32'h4000_0000);
		cyc(9);
		wr(8'h20, 32'h0);
		rd(8'h2C);
		a = q;
		cyc(5);
		rd(8'h2C);
		chk(q, a);
		wr(8'h20, 32'h4000_0000);
		// enable lands at the last edge of the write; let the count move
		cyc(2);
		rd(8'h2C);
		chk(q > a && q < a + 32'h8, 1'h1);
		wr(8'h20, 32'h4400_0000);
		// the clear strobe reaches the counter one edge after the write lands
		cyc(2);
		rd(8'h2C);
		chk(q, 32'h0);
		rd(8'h20);
		chk(q, 32'h0);
	endtask
	task automatic t_src;
		for (int s = 1; s < 4; s++) begin
			wr(8'h30, s);
			wr(8'h20, 32'h4000_0000);
			repeat (s * 3) begin
				ext_clk_src[s - 1] <= 1'h1;
				cyc(3);
				ext_clk_src[s - 1] <= 1'h0;
				cyc(3);
			end
			cyc(4);
			rd(8'h2C);
			chk(q, s * 3);
			wr(8'h20, 32'h0400_0000);
		end
	endtask
	initial begin
		fails = 0;
		num_checks = 0;
		hresetn = 1'h0;
		ext_clk_src = 3'h0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		t_reset;
		t_oneshot;
		t_toggle;
		t_cont;
		t_clear;
		t_src;
		print_verdict;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		print_verdict;
	end
endmodule
`default_nettype wire
